// ### eip_sync.sv
package eip_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CCR = 4'h1;
  localparam logic [3:0] OFS_INT_STAT = 4'h2;
  localparam logic [3:0] OFS_INT_MASK = 4'h3;
  localparam int BIT_PE = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_MODE = 2;
  localparam int BIT_PDD = 3;
  localparam int BIT_IE = 4;
  localparam int BIT_PEND = 5;
  localparam int BIT_ACK = 6;
  localparam int BIT_LEVEL = 7;
  localparam int BIT_GMASK = 0;
  localparam int EV_EDGE = 0;
  localparam int EV_WAKE = 1;
  localparam int NUM_EV = 2;
  localparam logic [NUM_EV-1:0] INT_MASK_RST = 2'h0;
  localparam logic GMASK_RST = 1'b1;
  localparam logic [15:0] VEC_BASE_DEF = 16'hffc0;

  typedef struct packed {
    logic ie;
    logic pdd;
    logic mode;
    logic pol;
    logic pe;
  } eip_ctrl_s;

  localparam eip_ctrl_s CTRL_RST = '{ie: 1'b0, pdd: 1'b0, mode: 1'b0,
                                     pol: 1'b0, pe: 1'b0};

  typedef struct packed {
    logic pull_up_en;
    logic pull_dn_en;
  } eip_pull_s;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_STK_PCL = 4'h1,
    SEQ_STK_PCH = 4'h2,
    SEQ_STK_X = 4'h3,
    SEQ_STK_A = 4'h4,
    SEQ_STK_CCR = 4'h5,
    SEQ_VEC_HI = 4'h6,
    SEQ_VEC_LO = 4'h7,
    SEQ_VEC_DONE = 4'h8
  } eip_seq_e;
endpackage

`timescale 1ns/1ps
`default_nettype none
module eip_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  // Two stages; only the second is read downstream
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### eip_top.sv
// Notes on behaviour
// - Pin is an interrupt input only while pin_func_enable is 1.
// - Enabled pin is sampled by logic on the system clock.
// - polarity_select picks falling/low or rising/high as asserted.
// - detect_mode picks edge-only or edge-and-level detection.
// - Events always set pending_flag; request only with local enable.
// - pull_disable 0 on an enabled pin: pull-up for low polarity, pull-down for high.
// - pull_disable 1 switches the internal pull device off.
// - Enabled pin level is offered to the branch-on-level instructions.
// - Deasserted to asserted transition sets pending_flag. Here not while stop_mode is 1.
// - Edge-and-level: flag stays set while pin is asserted.
// - In stop mode a separate detection path raises wake-up.
// - Vector high byte at first address, low byte at next.
// - Highest index pending source wins, fixed ordering.
// - Source flag sets; forwarded only when its enable is 1.
// - Mask clear: finish, stack PC_LOW_BYTE PC_HIGH_BYTE X A CONDITION_REGISTER, mask, fetch vector. Here the mask is set at the take, before stacking.
// - Global mask is set after any reset.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module eip_top #(
  parameter int NSRC = 4,
  parameter logic [15:0] VEC_BASE = eip_pkg::VEC_BASE_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_pin,
  input wire logic stop_mode,
  input wire logic [eip_pkg::ADDR_W-1:0] addr,
  input wire logic [eip_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [eip_pkg::DATA_W-1:0] rdata,
  input wire logic [NSRC-2:0] src_req_in,
  input wire logic insn_done,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [3:0] seq_step,
  output logic [15:0] isr_addr,
  output logic isr_valid,
  output logic global_mask,
  output logic pin_level,
  output logic pull_up_en,
  output logic pull_dn_en,
  output logic wake_req,
  output logic irq
);
  eip_pkg::eip_ctrl_s ctrl;
  eip_pkg::eip_seq_e state;
  eip_pkg::eip_seq_e next_state;
  logic pin_s;
  logic asserted;
  logic prev_asserted;
  logic pin_edge;
  logic pending_flag;
  logic ack_w;
  logic ext_req;
  logic [NSRC-1:0] src_all;
  logic take;
  logic [$clog2(NSRC)-1:0] sel_q;
  logic [15:0] vec_addr_q;
  logic [7:0] isr_hi;
  logic [eip_pkg::NUM_EV-1:0] int_stat;
  logic [eip_pkg::NUM_EV-1:0] int_mask;
  logic [eip_pkg::NUM_EV-1:0] ev;
  logic stat_rd;

  function automatic logic [$clog2(NSRC)-1:0] top_index(
    input logic [NSRC-1:0] req
  );
    logic [$clog2(NSRC)-1:0] idx;
    idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i]) begin
        idx = i[$clog2(NSRC)-1:0];
      end
    end
    return idx;
  endfunction

  function automatic logic reg_hit(
    input logic [eip_pkg::ADDR_W-1:0] a,
    input logic [eip_pkg::ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  eip_sync #(.W(1)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(irq_pin),
    .q(pin_s)
  );

  // Disabled pin never counts as asserted
  assign asserted = ctrl.pe & (ctrl.pol ? pin_s : ~pin_s);
  assign pin_edge = asserted & ~prev_asserted & ~stop_mode;
  assign ack_w = wr & reg_hit(addr, eip_pkg::OFS_CTRL) &
                 wdata[eip_pkg::BIT_ACK];
  assign ext_req = pending_flag & ctrl.ie;
  assign src_all = {ext_req, src_req_in};
  assign take = (state == eip_pkg::SEQ_IDLE) & (|src_all) &
                ~global_mask & insn_done;
  assign stat_rd = rd & reg_hit(addr, eip_pkg::OFS_INT_STAT);
  assign ev = {wake_req == 1'b0 && stop_mode && asserted, pin_edge};

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_asserted <= 1'b0;
    end else begin
      prev_asserted <= asserted;
    end
  end

  // Acknowledge loses to a fresh edge or, in edge-and-level mode, a held level
  always_ff @(posedge mclk) begin
    if (rst) begin
      pending_flag <= 1'b0;
    end else begin
      pending_flag <= pin_edge | (ctrl.mode & asserted) |
                      (pending_flag & ~ack_w);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= eip_pkg::CTRL_RST;
    end else if (wr & reg_hit(addr, eip_pkg::OFS_CTRL)) begin
      ctrl.pe <= wdata[eip_pkg::BIT_PE];
      ctrl.pol <= wdata[eip_pkg::BIT_POL];
      ctrl.mode <= wdata[eip_pkg::BIT_MODE];
      ctrl.pdd <= wdata[eip_pkg::BIT_PDD];
      ctrl.ie <= wdata[eip_pkg::BIT_IE];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pull_up_en <= 1'b0;
      pull_dn_en <= 1'b0;
    end else begin
      pull_up_en <= ctrl.pe & ~ctrl.pdd & ~ctrl.pol;
      pull_dn_en <= ctrl.pe & ~ctrl.pdd & ctrl.pol;
    end
  end

  // Raw level, not polarity adjusted, as the branch instructions expect
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_level <= 1'b0;
    end else if (ctrl.pe) begin
      pin_level <= pin_s;
    end
  end

  // Clock-gated stop is not modelled; needs mclk kept alive to wake
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= stop_mode & asserted;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      global_mask <= eip_pkg::GMASK_RST;
    end else if (take) begin
      global_mask <= 1'b1;
    end else if (wr & reg_hit(addr, eip_pkg::OFS_CCR)) begin
      global_mask <= wdata[eip_pkg::BIT_GMASK];
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      eip_pkg::SEQ_IDLE: begin
        if (take) begin
          next_state = eip_pkg::SEQ_STK_PCL;
        end
      end
      eip_pkg::SEQ_STK_PCL: next_state = eip_pkg::SEQ_STK_PCH;
      eip_pkg::SEQ_STK_PCH: next_state = eip_pkg::SEQ_STK_X;
      eip_pkg::SEQ_STK_X: next_state = eip_pkg::SEQ_STK_A;
      eip_pkg::SEQ_STK_A: next_state = eip_pkg::SEQ_STK_CCR;
      eip_pkg::SEQ_STK_CCR: next_state = eip_pkg::SEQ_VEC_HI;
      eip_pkg::SEQ_VEC_HI: next_state = eip_pkg::SEQ_VEC_LO;
      eip_pkg::SEQ_VEC_LO: next_state = eip_pkg::SEQ_VEC_DONE;
      eip_pkg::SEQ_VEC_DONE: next_state = eip_pkg::SEQ_IDLE;
      default: next_state = eip_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= eip_pkg::SEQ_IDLE;
      seq_step <= 4'h0;
    end else begin
      state <= next_state;
      seq_step <= next_state;
    end
  end

  // Source chosen at the take; later arrivals wait for the next one
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_q <= '0;
      vec_addr_q <= 16'h0000;
    end else if (take) begin
      sel_q <= top_index(src_all);
      vec_addr_q <= VEC_BASE + 16'({top_index(src_all), 1'b0});
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_addr <= 16'h0000;
    end else if (next_state == eip_pkg::SEQ_VEC_HI) begin
      mem_addr <= vec_addr_q;
    end else if (next_state == eip_pkg::SEQ_VEC_LO) begin
      mem_addr <= vec_addr_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      isr_hi <= 8'h00;
      isr_addr <= 16'h0000;
      isr_valid <= 1'b0;
    end else begin
      isr_valid <= state == eip_pkg::SEQ_VEC_DONE;
      if (state == eip_pkg::SEQ_VEC_LO) begin
        isr_hi <= mem_rdata;
      end
      if (state == eip_pkg::SEQ_VEC_DONE) begin
        isr_addr <= {isr_hi, mem_rdata};
      end
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & {eip_pkg::NUM_EV{~stat_rd}}) | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_mask <= eip_pkg::INT_MASK_RST;
    end else if (wr & reg_hit(addr, eip_pkg::OFS_INT_MASK)) begin
      int_mask <= wdata[eip_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat & {eip_pkg::NUM_EV{~stat_rd}}) | ev) & int_mask);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          eip_pkg::OFS_CTRL: begin
            rdata <= {pin_s, 1'b0, pending_flag, ctrl.ie, ctrl.pdd,
                      ctrl.mode, ctrl.pol, ctrl.pe};
          end
          eip_pkg::OFS_CCR: rdata <= {7'h00, global_mask};
          eip_pkg::OFS_INT_STAT: rdata <= {6'h00, int_stat};
          eip_pkg::OFS_INT_MASK: rdata <= {6'h00, int_mask};
          default: rdata <= '0;
        endcase
      end
    end
  end

  AST_DISABLED_NO_EDGE: assert property (@(posedge mclk) disable iff (rst)
    !ctrl.pe |-> !pin_edge) else $error("edge seen while pin disabled");
  AST_EDGE_SETS: assert property (@(posedge mclk) disable iff (rst)
    pin_edge |=> pending_flag) else $error("edge did not set flag");
  AST_LEVEL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (ctrl.mode && asserted && ack_w) |=> pending_flag)
    else $error("flag cleared while level asserted");
  AST_EDGE_ONLY_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (pending_flag && !ack_w) |=> pending_flag)
    else $error("flag dropped without acknowledge");
  AST_ACK_CLEARS: assert property (@(posedge mclk) disable iff (rst)
    (ack_w && !ctrl.mode && !pin_edge) |=> !pending_flag)
    else $error("acknowledge did not clear flag");
  // Held level alone must not raise the flag in edge-only mode
  AST_EDGE_ONLY_NO_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    (!ctrl.mode && !pending_flag && !pin_edge) |=> !pending_flag)
    else $error("flag set without edge");
  AST_RESET_MASK: assert property (@(posedge mclk)
    rst |=> global_mask) else $error("mask clear after reset");
  AST_TAKE_MASKS: assert property (@(posedge mclk) disable iff (rst)
    take |=> global_mask && state == eip_pkg::SEQ_STK_PCL)
    else $error("take did not mask and stack");
  AST_STACK_ORDER: assert property (@(posedge mclk) disable iff (rst)
    state == eip_pkg::SEQ_STK_PCL |=> state == eip_pkg::SEQ_STK_PCH
    ##1 state == eip_pkg::SEQ_STK_X ##1 state == eip_pkg::SEQ_STK_A
    ##1 state == eip_pkg::SEQ_STK_CCR ##1 state == eip_pkg::SEQ_VEC_HI)
    else $error("stacking order broken");
  AST_VEC_BYTES: assert property (@(posedge mclk) disable iff (rst)
    state == eip_pkg::SEQ_VEC_HI |-> mem_addr == vec_addr_q
    ##1 mem_addr == vec_addr_q + 16'h0001)
    else $error("vector byte addresses wrong");
  AST_PRIORITY: assert property (@(posedge mclk) disable iff (rst)
    (take && src_all[NSRC-1]) |=> sel_q == NSRC - 1)
    else $error("lower source chosen over top");
  AST_NO_REQ_WITHOUT_IE: assert property (@(posedge mclk) disable iff (rst)
    (take && !ctrl.ie && src_all == {1'b0, src_req_in}) |=> sel_q != NSRC - 1)
    else $error("pin forwarded without enable");
  AST_PULL: assert property (@(posedge mclk) disable iff (rst)
    (ctrl.pe && !ctrl.pdd && !ctrl.pol) |=> pull_up_en && !pull_dn_en)
    else $error("pull-up not on");
  AST_PULL_OFF: assert property (@(posedge mclk) disable iff (rst)
    ctrl.pdd |=> !pull_up_en && !pull_dn_en)
    else $error("pull device not off");
  AST_LEVEL_OUT: assert property (@(posedge mclk) disable iff (rst)
    ctrl.pe |=> pin_level == $past(pin_s))
    else $error("pin level not passed on");
  AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
    (stop_mode && asserted) |=> wake_req)
    else $error("no wake in stop");
  AST_POLARITY: assert property (@(posedge mclk) disable iff (rst)
    (ctrl.pe && ctrl.pol && prev_asserted && !stop_mode) |-> !pin_edge)
    else $error("edge while already asserted");
endmodule
`default_nettype wire

// ### eip_pin_dev.sv
`timescale 1ns/1ps
`default_nettype none
module eip_pin_dev (
  input wire logic drive_en,
  input wire logic drive_val,
  input wire logic ext_pull,
  input wire logic pull_up_en,
  input wire logic pull_dn_en,
  output logic irq_pin
);
  // Released pin settles at the active pull, never at its last value
  always_comb begin
    if (drive_en) irq_pin = drive_val;
    else if (pull_up_en) irq_pin = 1'b1;
    else if (pull_dn_en) irq_pin = 1'b0;
    else irq_pin = ext_pull;
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, rst, stop_mode, wr, rd, insn_done, isr_valid, global_mask;
  logic irq_pin, pin_level, pull_up_en, pull_dn_en, wake_req, irq;
  logic drv_en, drv_val, ext_pull, rd_seen, pol, mode;
  logic [3:0] addr, seq_step;
  logic [7:0] wdata, rdata, mem_rdata, cfg;
  logic [2:0] src_req_in;
  logic [15:0] mem_addr, isr_addr;
  logic [31:0] rng;
  logic [7:0] exp_q[$];
  logic [15:0] isr_q[$];
  int err_total, n_checks;

  eip_top #(.NSRC(4)) i_dut (.mclk(mclk), .rst(rst), .irq_pin(irq_pin),
    .stop_mode(stop_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_req_in(src_req_in), .insn_done(insn_done),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .seq_step(seq_step),
    .isr_addr(isr_addr), .isr_valid(isr_valid), .global_mask(global_mask),
    .pin_level(pin_level), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .wake_req(wake_req), .irq(irq));

  eip_pin_dev i_dev (.drive_en(drv_en), .drive_val(drv_val),
    .ext_pull(ext_pull), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .irq_pin(irq_pin));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Vector memory contents, distinct per low address byte
  function automatic logic [7:0] mem_f(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Mismatches %0d, checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) check("rdata", {8'h00, rdata}, exp_q.pop_front());
    if (isr_valid === 1'b1) check("isr_addr", isr_addr, isr_q.pop_front());
    rd_seen <= rd;
    mem_rdata <= mem_f(mem_addr);
  end

  initial begin
    #1000000;
    err_total++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    stop_mode = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    insn_done = 1'b0;
    src_req_in = 3'h0;
    drv_en = 1'b1;
    drv_val = 1'b0;
    ext_pull = 1'b0;
    rng = 32'hae628c74;
    err_total = 0;
    n_checks = 0;
    tick(20);
    rst <= 1'b0;
    check("global_mask", global_mask, 1'b1);
    rreg(eip_pkg::OFS_CCR, 8'h01);
    rreg(4'hf, 8'h00);
    // Pulse on a disabled pin
    drv_val <= 1'b1;
    tick(4);
    drv_val <= 1'b0;
    tick(4);
    rreg(eip_pkg::OFS_CTRL, 8'h00);
    rreg(eip_pkg::OFS_INT_STAT, 8'h00);
    for (int m = 0; m < 4; m++) begin
      pol = m[0];
      mode = m[1];
      cfg = {5'h00, mode, pol, 1'b1};
      // Deassert before enabling, else enabling counts as an edge
      drv_en <= 1'b1;
      drv_val <= !pol;
      tick(4);
      wreg(eip_pkg::OFS_CTRL, cfg);
      // Pull is on one cycle after enable; release earlier floats the pin
      tick(2);
      drv_en <= 1'b0;
      tick(1);
      check("pull_up_en", pull_up_en, !pol);
      check("pull_dn_en", pull_dn_en, pol);
      rreg(eip_pkg::OFS_CTRL, {!pol, 2'h0, cfg[4:0]});
      drv_en <= 1'b1;
      drv_val <= pol;
      tick(5);
      check("pin_level", pin_level, pol);
      rreg(eip_pkg::OFS_CTRL, {pol, 2'h1, cfg[4:0]});
      if (mode) begin
        wreg(eip_pkg::OFS_CTRL, cfg | 8'h40);
        rreg(eip_pkg::OFS_CTRL, {pol, 2'h1, cfg[4:0]});
      end
      drv_val <= !pol;
      tick(5);
      rreg(eip_pkg::OFS_CTRL, {!pol, 2'h1, cfg[4:0]});
      wreg(eip_pkg::OFS_CTRL, cfg | 8'h40);
      rreg(eip_pkg::OFS_CTRL, {!pol, 2'h0, cfg[4:0]});
      wreg(eip_pkg::OFS_CTRL, 8'h00);
    end
    check("irq", irq, 1'b0);
    rreg(eip_pkg::OFS_INT_STAT, 8'h01);
    drv_en <= 1'b0;
    ext_pull <= 1'b1;
    tick(3);
    wreg(eip_pkg::OFS_CTRL, 8'h09);
    tick(2);
    check("pull_up_en", pull_up_en, 1'b0);
    check("pull_dn_en", pull_dn_en, 1'b0);
    wreg(eip_pkg::OFS_INT_MASK, 8'h01);
    wreg(eip_pkg::OFS_CTRL, 8'h19);
    drv_en <= 1'b1;
    drv_val <= 1'b0;
    tick(5);
    check("irq", irq, 1'b1);
    check("seq_step", seq_step, 4'h0);
    rreg(eip_pkg::OFS_INT_STAT, 8'h01);
    tick(2);
    check("irq", irq, 1'b0);
    // Lower sources requesting too; the pin still wins
    rng = xs(rng);
    src_req_in <= rng[2:0];
    insn_done <= 1'b1;
    isr_q.push_back({mem_f(eip_pkg::VEC_BASE_DEF + 16'h0006),
                     mem_f(eip_pkg::VEC_BASE_DEF + 16'h0007)});
    wreg(eip_pkg::OFS_CCR, 8'h00);
    for (int i = 0; i < 10 && seq_step !== 4'h1; i++) tick(1);
    for (int s = 2; s < 9; s++) begin
      tick(1);
      check("seq_step", seq_step, 16'(s));
    end
    check("global_mask", global_mask, 1'b1);
    tick(3);
    src_req_in <= 3'h0;
    insn_done <= 1'b0;
    wreg(eip_pkg::OFS_CTRL, 8'h59);
    drv_val <= 1'b1;
    tick(4);
    stop_mode <= 1'b1;
    drv_val <= 1'b0;
    tick(5);
    check("wake_req", wake_req, 1'b1);
    rreg(eip_pkg::OFS_INT_STAT, 8'h02);
    rreg(eip_pkg::OFS_CTRL, 8'h19);
    tick(2);
    stop_test();
  end
endmodule
`default_nettype wire
